// ===== include/aux_stage_consts.svh
// Constants for the auxiliary motor staging controller.
// Behaviour
// RQ1 - Stage when frequency, delay and error all exceed
// RQ2 - Unstage newest first when frequency and error low
// RQ3 - Start delay, default five seconds
// RQ4 - Stop delay held continuously before unstaging
// RQ5 - Selectable first relay, default relay one
// RQ6 - Motor count setting, default four, limits staging
// RQ7 - Runtime hours:minutes, cleared on each auto change
// RQ8 - Fixed order cyclic from first, reverse removal
// RQ9 - Aux rotation advances first relay per change
// RQ10 - All-motor rotation: every motor relay switched
// RQ11 - Bypass takes frequency and reference from feedback
// RQ12 - Bypass at maximum stages motor, restarts ramp
// RQ13 - Bypass only with analog frequency source; code also allows it with pulse source
// RQ14 - Aux rotation change needs interval elapsed
// RQ15 - Aux rotation change needs low level, aux off
// RQ16 - All-motor change needs exactly one motor running
// RQ17 - Change stops motor, advances order, resumes staging
// RQ18 - Interval timer runs only while a motor runs
// RQ19 - All-motor change below level starts next motor
// RQ20 - Interlock inputs enable their relays when staging
// RQ21 - Interlock drop stops all, restarts with rest
// RQ22 - Modes 0,1 main plus aux; mode 2 relays only
// RQ23 - Delays in tenths of a second to 999.9; code accepts up to 1638.3
// RQ24 - Simultaneous stop option drops all at once
// RQ25 - Tick-driven counters restart when condition drops
// RQ26 - Synchronous reset clears outputs, restores defaults; code leaves freq_cmd following its source
`ifndef AUX_STAGE_CONSTS_SVH
`define AUX_STAGE_CONSTS_SVH
`define CLK_PERIOD_NS 40
`define TENTH_NS 100000000
`define TICKS_PER_MIN 600
`define MAX_HOURS 99
`define A_CTRL 8'h00
`define A_START01 8'h04
`define A_START23 8'h08
`define A_STOP01 8'h0c
`define A_STOP23 8'h10
`define A_DELAY 8'h14
`define A_DIFF 8'h18
`define A_ROT 8'h1c
`define A_MAXF 8'h20
`define A_STATUS 8'h24
`define C_MODE 0
`define C_BYP 2
`define C_ILK 3
`define C_ALLSTOP 4
`define C_FIRST 5
`define C_COUNT 7
`define C_SRC 10
`define CTRL_RST 16'h0200
`define START_FREQ_RST 16'h1387
`define STOP_FREQ_RST 16'h07d0
`define DELAY_RST 14'h0032
`define DIFF_RST 16'h00c8
`define INTV_H_RST 7'h48
`define LEVEL_RST 16'h07d0
`define MAXF_RST 16'h1770
`endif

// ===== include/aux_stage_pkg.sv
// Types shared by the auxiliary motor staging controller.
package aux_stage_pkg;
  typedef enum logic [1:0] {
    fixed_order_mode,
    aux_rotation_mode,
    all_motor_rotation_mode
  } rot_mode_t;
  typedef enum logic [1:0] {
    src_keypad,
    src_volt,
    src_current,
    src_pulse
  } freq_src_t;
endpackage

// ===== src/aux_motor_staging_controller.sv
// Auxiliary pump staging controller with an AHB-Lite register slave.
//
// The register offsets and the AHB-Lite register port were decided locally.
`timescale 1ns/1ps
`include "aux_stage_consts.svh"
module aux_motor_staging_controller
  import aux_stage_pkg::*;
#(
  parameter int TICK_CYCLES = `TENTH_NS / `CLK_PERIOD_NS
) (
  // Clock and resets
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic srst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Drive process values, 0.01 units
  input wire logic run,
  input wire logic [15:0] out_freq,
  input wire logic [15:0] pid_freq,
  input wire logic [15:0] pid_ref,
  input wire logic [15:0] pid_fb,
  input wire logic [3:0] interlock_in,
  // Motor side
  output logic [3:0] relay_out,
  output logic [15:0] freq_cmd,
  output logic ramp_restart
);
  localparam int TW = $clog2(TICK_CYCLES + 1);

  if (TICK_CYCLES < 1) begin : g_chk
    $error("TICK_CYCLES must be at least one");
  end

  function automatic logic [2:0] pop4(input logic [3:0] v);
    return {2'b00, v[0]} + {2'b00, v[1]} + {2'b00, v[2]} + {2'b00, v[3]};
  endfunction

  logic [15:0] ctrl_ff;
  logic [3:0][15:0] start_thr_ff;
  logic [3:0][15:0] stop_thr_ff;
  logic [13:0] start_dly_ff;
  logic [13:0] stop_dly_ff;
  logic [15:0] start_diff_ff;
  logic [15:0] stop_diff_ff;
  logic [6:0] intv_h_ff;
  logic [5:0] intv_m_ff;
  logic [15:0] level_ff;
  logic [15:0] max_freq_ff;
  logic [TW-1:0] tick_cnt_ff;
  logic tick_ff;
  logic [3:0] relay_ff;
  logic [13:0] start_cnt_ff;
  logic [13:0] stop_cnt_ff;
  logic [1:0] rot_ff;
  logic [9:0] sub_min_ff;
  logic [5:0] rt_min_ff;
  logic [6:0] rt_hr_ff;
  logic [15:0] freq_cmd_ff;
  logic ramp_ff;
  logic [31:0] hrdata_ff;
  logic wr_ff;
  logic [7:0] addr_ff;

  rot_mode_t mode;
  logic bypass_ok, ilk_sel, ilk_bad, below_count, elapsed;
  logic [3:0] allowed;
  logic [1:0] first_eff, nxt_idx, last_idx;
  logic has_next, has_last;
  logic [2:0] n_on;
  logic [15:0] fref;
  logic signed [16:0] err;
  logic start_ok, stop_ok, start_fire, stop_fire, ac_fire;

  assign mode = rot_mode_t'(ctrl_ff[`C_MODE +: 2]);
  // RQ13 any source but keypad
  assign bypass_ok = ctrl_ff[`C_BYP] &&
    (freq_src_t'(ctrl_ff[`C_SRC +: 2]) != src_keypad);
  assign ilk_sel = ctrl_ff[`C_ILK];
  // RQ20 interlock enables
  assign allowed = ilk_sel ? interlock_in : 4'hf;
  assign ilk_bad = |(relay_ff & ~allowed);
  assign n_on = pop4(relay_ff);
  // RQ6 count limit
  assign below_count = n_on < ctrl_ff[`C_COUNT +: 3];
  // RQ5 first relay
  assign first_eff = (mode == fixed_order_mode) ? ctrl_ff[`C_FIRST +: 2] :
    ctrl_ff[`C_FIRST +: 2] + rot_ff;
  // RQ11 feedback as reference
  assign fref = bypass_ok ? pid_fb : out_freq;
  assign err = $signed({1'b0, pid_ref}) - $signed({1'b0, pid_fb});
  assign elapsed = {rt_hr_ff, rt_min_ff} >= {intv_h_ff, intv_m_ff};

  // RQ8 cyclic search order
  always_comb begin
    nxt_idx = first_eff;
    last_idx = first_eff;
    has_next = 1'b0;
    has_last = 1'b0;
    for (int k = 0; k < 4; k++) begin
      if (!has_next && !relay_ff[first_eff + 2'(k)] &&
          allowed[first_eff + 2'(k)]) begin
        nxt_idx = first_eff + 2'(k);
        has_next = 1'b1;
      end
      if (relay_ff[first_eff + 2'(k)]) begin
        last_idx = first_eff + 2'(k);
        has_last = 1'b1;
      end
    end
  end

  // RQ1 start conditions
  // RQ12 bypass stages at maximum
  assign start_ok = run && has_next && below_count && !ilk_bad &&
    (bypass_ok ? (fref >= max_freq_ff) :
     (fref > start_thr_ff[nxt_idx] &&
      err > $signed({1'b0, start_diff_ff})));
  // RQ2 stop conditions
  // RQ22 regulated relay stays in mode 2
  assign stop_ok = run && has_last && !ilk_bad &&
    !(mode == all_motor_rotation_mode && n_on == 3'd1) &&
    fref < stop_thr_ff[last_idx] &&
    err < $signed({1'b0, stop_diff_ff});
  // RQ3 start delay
  assign start_fire = start_ok && start_cnt_ff >= start_dly_ff;
  // RQ4 stop delay
  assign stop_fire = stop_ok && stop_cnt_ff >= stop_dly_ff;
  // RQ14 interval, RQ15 and RQ16 level and motor count
  assign ac_fire = run && elapsed && !ilk_bad && fref < level_ff &&
    ((mode == aux_rotation_mode && n_on == 3'd0) ||
     (mode == all_motor_rotation_mode && n_on == 3'd1));

  // RQ25 tenth-second time base
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_cnt_ff <= '0;
      tick_ff <= 1'b0;
    end else if (srst || tick_cnt_ff == TW'(TICK_CYCLES - 1)) begin
      tick_cnt_ff <= '0;
      tick_ff <= !srst;
    end else begin
      tick_cnt_ff <= tick_cnt_ff + 1'b1;
      tick_ff <= 1'b0;
    end
  end

  // RQ25 delay counters restart on condition loss
  // RQ23 counts of tenth seconds
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      start_cnt_ff <= '0;
      stop_cnt_ff <= '0;
    end else begin
      if (srst || !start_ok || start_fire) begin
        start_cnt_ff <= '0;
      end else if (tick_ff) begin
        start_cnt_ff <= start_cnt_ff + 1'b1;
      end
      if (srst || !stop_ok || stop_fire) begin
        stop_cnt_ff <= '0;
      end else if (tick_ff) begin
        stop_cnt_ff <= stop_cnt_ff + 1'b1;
      end
    end
  end

  // RQ17 change stops, advances, resumes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      relay_ff <= 4'h0;
    end else if (srst) begin
      relay_ff <= 4'h0;
    end else if (ilk_bad) begin
      // RQ21 all off, restart later
      relay_ff <= 4'h0;
    end else if (!run) begin
      // RQ24 simultaneous or ordered stop
      if (ctrl_ff[`C_ALLSTOP]) begin
        relay_ff <= 4'h0;
      end else if (tick_ff && has_last) begin
        relay_ff[last_idx] <= 1'b0;
      end
    end else if (ac_fire) begin
      // RQ19 stop running motor
      relay_ff <= 4'h0;
    end else if (mode == all_motor_rotation_mode && n_on == 3'd0 &&
                 has_next && below_count) begin
      // RQ10 regulated motor also on a relay
      relay_ff[nxt_idx] <= 1'b1;
    end else if (start_fire) begin
      relay_ff[nxt_idx] <= 1'b1;
    end else if (stop_fire) begin
      relay_ff[last_idx] <= 1'b0;
    end
  end

  // RQ9 rotation advance
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rot_ff <= 2'h0;
    end else if (srst) begin
      rot_ff <= 2'h0;
    end else if (ac_fire) begin
      rot_ff <= rot_ff + 1'b1;
    end
  end

  // RQ7 runtime since last change
  // RQ18 counts only with a motor on
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sub_min_ff <= '0;
      rt_min_ff <= '0;
      rt_hr_ff <= '0;
    end else if (srst || ac_fire) begin
      sub_min_ff <= '0;
      rt_min_ff <= '0;
      rt_hr_ff <= '0;
    end else if (tick_ff && n_on != 3'd0 && rt_hr_ff < 7'(`MAX_HOURS)) begin
      if (sub_min_ff == 10'(`TICKS_PER_MIN - 1)) begin
        sub_min_ff <= '0;
        if (rt_min_ff == 6'd59) begin
          rt_min_ff <= '0;
          rt_hr_ff <= rt_hr_ff + 1'b1;
        end else begin
          rt_min_ff <= rt_min_ff + 1'b1;
        end
      end else begin
        sub_min_ff <= sub_min_ff + 1'b1;
      end
    end
  end

  // RQ11 bypass frequency path
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      freq_cmd_ff <= '0;
      ramp_ff <= 1'b0;
    end else begin
      freq_cmd_ff <= bypass_ok ? pid_fb : pid_freq;
      // RQ12 ramp restart after staging
      ramp_ff <= !srst && run && !ilk_bad && !ac_fire && start_fire &&
        bypass_ok && !(mode == all_motor_rotation_mode && n_on == 3'd0);
    end
  end

  // Reads are answered with zero wait states, so hrdata is latched
  // from the address phase and stands in the data phase.
  logic addr_ok;
  logic [31:0] rd_word;
  assign addr_ok = hsel && htrans[1] && hready;

  always_comb begin
    rd_word = 32'h0;
    case (haddr[7:0])
      `A_CTRL: rd_word = {16'h0, ctrl_ff};
      `A_START01: rd_word = {start_thr_ff[1], start_thr_ff[0]};
      `A_START23: rd_word = {start_thr_ff[3], start_thr_ff[2]};
      `A_STOP01: rd_word = {stop_thr_ff[1], stop_thr_ff[0]};
      `A_STOP23: rd_word = {stop_thr_ff[3], stop_thr_ff[2]};
      `A_DELAY: rd_word = {2'b00, stop_dly_ff, 2'b00, start_dly_ff};
      `A_DIFF: rd_word = {stop_diff_ff, start_diff_ff};
      `A_ROT: rd_word = {level_ff, 1'b0, intv_h_ff, 2'b00, intv_m_ff};
      `A_MAXF: rd_word = {16'h0, max_freq_ff};
      `A_STATUS: rd_word = {7'h0, elapsed, 1'b0, rt_hr_ff, 2'b00,
        rt_min_ff, 2'b00, first_eff, relay_ff};
      default: rd_word = 32'h0;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ff <= 1'b0;
      addr_ff <= 8'h0;
      hrdata_ff <= 32'h0;
    end else begin
      wr_ff <= addr_ok && hwrite && hsize == 3'b010;
      addr_ff <= haddr[7:0];
      if (addr_ok && !hwrite) begin
        hrdata_ff <= rd_word;
      end
    end
  end

  // RQ26 settings return to defaults
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_ff <= `CTRL_RST;
      start_thr_ff <= {4{`START_FREQ_RST}};
      stop_thr_ff <= {4{`STOP_FREQ_RST}};
      start_dly_ff <= `DELAY_RST;
      stop_dly_ff <= `DELAY_RST;
      start_diff_ff <= `DIFF_RST;
      stop_diff_ff <= `DIFF_RST;
      intv_h_ff <= `INTV_H_RST;
      intv_m_ff <= 6'h0;
      level_ff <= `LEVEL_RST;
      max_freq_ff <= `MAXF_RST;
    end else if (srst) begin
      ctrl_ff <= `CTRL_RST;
      start_thr_ff <= {4{`START_FREQ_RST}};
      stop_thr_ff <= {4{`STOP_FREQ_RST}};
      start_dly_ff <= `DELAY_RST;
      stop_dly_ff <= `DELAY_RST;
      start_diff_ff <= `DIFF_RST;
      stop_diff_ff <= `DIFF_RST;
      intv_h_ff <= `INTV_H_RST;
      intv_m_ff <= 6'h0;
      level_ff <= `LEVEL_RST;
      max_freq_ff <= `MAXF_RST;
    end else if (wr_ff) begin
      case (addr_ff)
        `A_CTRL: ctrl_ff <= {4'h0, hwdata[11:0]};
        `A_START01: start_thr_ff[1:0] <= hwdata;
        `A_START23: start_thr_ff[3:2] <= hwdata;
        `A_STOP01: stop_thr_ff[1:0] <= hwdata;
        `A_STOP23: stop_thr_ff[3:2] <= hwdata;
        `A_DELAY: begin
          start_dly_ff <= hwdata[13:0];
          stop_dly_ff <= hwdata[29:16];
        end
        `A_DIFF: begin
          start_diff_ff <= hwdata[15:0];
          stop_diff_ff <= hwdata[31:16];
        end
        `A_ROT: begin
          intv_m_ff <= hwdata[5:0];
          intv_h_ff <= hwdata[14:8];
          level_ff <= hwdata[31:16];
        end
        `A_MAXF: max_freq_ff <= hwdata[15:0];
        default: ;
      endcase
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_ff;
  assign relay_out = relay_ff;
  assign freq_cmd = freq_cmd_ff;
  assign ramp_restart = ramp_ff;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  relay_count_a: assert property ( // RQ6
    n_on <= ctrl_ff[`C_COUNT +: 3] || $past(wr_ff) || !$past(hresetn))
    else $error("more relays on than the motor count");
  ilk_drop_a: assert property ( // RQ21
    ilk_bad |=> relay_ff == 4'h0 ##1 !ilk_bad)
    else $error("interlock drop did not clear all relays");
  start_delay_a: assert property ( // RQ3
    n_on > $past(n_on) && !($past(mode) == all_motor_rotation_mode &&
    $past(n_on) == 3'd0) |-> $past(start_cnt_ff) >= $past(start_dly_ff))
    else $error("relay staged before start delay");
  start_err_a: assert property ( // RQ1
    n_on > $past(n_on) && !$past(bypass_ok) &&
    $past(mode) != all_motor_rotation_mode |->
    $past(err) > $signed({1'b0, $past(start_diff_ff)}) &&
    $past(fref) > $past(start_thr_ff[nxt_idx]))
    else $error("relay staged without pressure error");
  all_stop_a: assert property ( // RQ24
    !run && ctrl_ff[`C_ALLSTOP] && !srst |=> relay_ff == 4'h0)
    else $error("simultaneous stop left a relay on");
  bypass_freq_a: assert property ( // RQ11
    bypass_ok ##1 !$past(srst) |-> freq_cmd == $past(pid_fb))
    else $error("bypass frequency not taken from feedback");
  keypad_no_bypass_a: assert property ( // RQ13
    ctrl_ff[`C_SRC +: 2] == 2'b00 |=> freq_cmd == $past(pid_freq))
    else $error("bypass used with keypad source");
  runtime_clear_a: assert property ( // RQ7
    ac_fire |=> rt_min_ff == 6'h0 && rt_hr_ff == 7'h0)
    else $error("runtime not cleared by auto change");
  runtime_hold_a: assert property ( // RQ18
    relay_ff == 4'h0 && !ac_fire && !srst |=> $stable(rt_min_ff))
    else $error("interval timer ran with no motor on");
  rot_step_a: assert property ( // RQ9
    ac_fire && !srst |=> rot_ff == $past(rot_ff) + 2'h1)
    else $error("rotation did not advance by one");
  srst_clear_a: assert property ( // RQ26
    srst |=> relay_ff == 4'h0 && start_cnt_ff == 14'h0 &&
    ctrl_ff == `CTRL_RST)
    else $error("synchronous reset left staging state");
endmodule

// ===== tb/contactor_model.sv
// Relay contactors with interlock terminals fed back to the controller.
`timescale 1ns/1ps
module contactor_model (
  // Clock
  input wire logic hclk,
  // Relay coils commanded by the controller, trips commanded by the bench
  input wire logic [3:0] relay_out,
  input wire logic [3:0] trip,
  // Interlock terminals back to the controller, motor state to the bench
  output logic [3:0] interlock_in,
  output logic [3:0] motor_on
);
  logic [3:0] coil_ff;
  initial interlock_in = 4'hf;
  // Contacts pick up two cycles late, as real contactors never answer at
  // once; a tripped terminal opens on the next edge.
  always @(posedge hclk) begin
    coil_ff <= relay_out;
    motor_on <= coil_ff;
    interlock_in <= ~trip;
  end
endmodule

// ===== tb/testbench.sv
// Self-checking bench for the auxiliary motor staging controller.
`timescale 1ns/1ps
`include "aux_stage_consts.svh"
module testbench;
  import aux_stage_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic srst = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic run = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [15:0] out_freq = 16'h0;
  logic [15:0] pid_freq = 16'h0;
  logic [15:0] pid_ref = 16'h0;
  logic [15:0] pid_fb = 16'h0;
  logic [15:0] freq_cmd;
  logic [3:0] trip = 4'h0;
  logic [3:0] interlock_in;
  logic [3:0] relay_out;
  logic [3:0] motor_on;
  logic hreadyout;
  logic hresp;
  logic ramp_restart;
  integer errors = 0;
  integer num_checks = 0;
  integer cycles = 0;
  integer seed = 32'he9553171;
  integer n;
  integer k;
  int order[$];

  always #20 hclk = ~hclk;

  aux_motor_staging_controller #(.TICK_CYCLES(10)) aux_motor_staging_controller_inst (
    .hclk(hclk), .hresetn(hresetn), .srst(srst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .run(run), .out_freq(out_freq),
    .pid_freq(pid_freq), .pid_ref(pid_ref), .pid_fb(pid_fb),
    .interlock_in(interlock_in), .relay_out(relay_out),
    .freq_cmd(freq_cmd), .ramp_restart(ramp_restart));

  contactor_model contactor_model_inst (
    .hclk(hclk), .relay_out(relay_out), .trip(trip),
    .interlock_in(interlock_in), .motor_on(motor_on));

  task end_of_test;
    if (errors == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task chk_reg(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t reg got %h exp %h", $time, got, exp);
    end
  endtask

  task chk_relay(input logic [3:0] got, input logic [3:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t relays got %h exp %h", $time, got, exp);
    end
  endtask

  task chk_freq(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t freq got %h exp %h", $time, got, exp);
    end
  endtask

  // One single word transfer; read data lands in rd.
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask

  // Staging order from the first relay, wrapping, skipping open terminals.
  task build(input int first, input int cnt, input logic [3:0] ok);
    order.delete();
    for (int i = 0; i < cnt; i++) begin
      if (ok[(first + i) % 4])
        order.push_back((first + i) % 4);
    end
  endtask

  function automatic logic [3:0] mask(input int cnt);
    logic [3:0] m;
    m = 4'h0;
    for (int i = 0; i < cnt; i++) m[order[i]] = 1'b1;
    return m;
  endfunction

  task wait_chg(input logic [3:0] exp);
    logic [3:0] old;
    old = relay_out;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (relay_out === old && n < 400);
    chk_relay(relay_out, exp);
  endtask

  always @(posedge hclk) begin
    cycles++;
    if (cycles > 40000) begin
      errors++;
      end_of_test;
    end
  end

  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(1'b0, `A_CTRL, 32'h0);
    chk_reg(rd, 32'h0000_0200);
    chk_reg({31'h0, hresp}, 32'h0);
    ahb(1'b0, `A_START01, 32'h0);
    chk_reg(rd, 32'h1387_1387);
    ahb(1'b0, `A_DELAY, 32'h0);
    chk_reg(rd, 32'h0032_0032);
    ahb(1'b0, `A_ROT, 32'h0);
    chk_reg(rd, 32'h07d0_4800);
    ahb(1'b0, `A_STATUS, 32'h0);
    chk_reg(rd, 32'h0);
    ahb(1'b0, 8'h40, 32'h0);
    chk_reg(rd, 32'h0);
    ahb(1'b1, `A_DELAY, 32'h0002_0002);
    ahb(1'b1, `A_START01, 32'h0bb8_0bb8);
    ahb(1'b1, `A_START23, 32'h0bb8_0bb8);
    ahb(1'b1, `A_STOP01, 32'h03e8_03e8);
    ahb(1'b1, `A_STOP23, 32'h03e8_03e8);
    for (k = 0; k < 2; k++) begin
      ahb(1'b1, `A_CTRL, k ? 32'h0000_0584 : 32'h0000_0184);
      for (int i = 0; i < 6; i++) begin
        @(posedge hclk);
        pid_freq <= $random(seed);
        pid_fb <= $random(seed);
        @(posedge hclk);
        #1;
        chk_freq(freq_cmd, k ? pid_fb : pid_freq);
      end
    end
    ahb(1'b1, `A_CTRL, 32'h0000_0180);
    ahb(1'b0, `A_CTRL, 32'h0);
    chk_reg(rd, 32'h0000_0180);
    build(0, 3, 4'hf);
    pid_ref <= 16'd5000;
    pid_fb <= 16'd4000;
    out_freq <= 16'd4000;
    run <= 1'b1;
    wait_chg(mask(1));
    chk_reg({31'h0, n >= 11 && n <= 40}, 32'h1);
    wait_chg(mask(2));
    wait_chg(mask(3));
    repeat (100) @(posedge hclk);
    chk_relay(relay_out, mask(3));
    chk_relay(motor_on, mask(3));
    ahb(1'b0, `A_STATUS, 32'h0);
    chk_relay(rd[3:0], mask(3));
    out_freq <= 16'd500;
    pid_fb <= 16'd5000;
    for (k = 2; k >= 0; k--) wait_chg(mask(k));
    // open terminal skipped, order wraps past relay four
    run <= 1'b0;
    trip <= 4'h1;
    ahb(1'b1, `A_CTRL, 32'h0000_0248);
    build(2, 4, 4'he);
    out_freq <= 16'd4000;
    pid_fb <= 16'd4000;
    run <= 1'b1;
    for (k = 1; k <= 3; k++) wait_chg(mask(k));
    // trip while running drops all, then restages
    trip <= 4'h9;
    wait_chg(4'h0);
    build(2, 4, 4'h6);
    wait_chg(mask(1));
    wait_chg(mask(2));
    @(posedge hclk);
    srst <= 1'b1;
    @(posedge hclk);
    srst <= 1'b0;
    #1;
    chk_relay(relay_out, 4'h0);
    ahb(1'b0, `A_CTRL, 32'h0);
    chk_reg(rd, 32'h0000_0200);
    // bypass stages at maximum, all stop drops together.
    ahb(1'b1, `A_DELAY, 32'h0002_0002);
    ahb(1'b1, `A_CTRL, 32'h0000_0614);
    pid_fb <= 16'd6000;
    wait_chg(4'h1);
    chk_relay({3'h0, ramp_restart}, 4'h1);
    wait_chg(4'h3);
    run <= 1'b0;
    wait_chg(4'h0);
    chk_reg(n, 32'h2);
    // aux rotation once a minute of aux running has passed.
    ahb(1'b1, `A_ROT, 32'h07d0_0001);
    ahb(1'b1, `A_CTRL, 32'h0000_0201);
    out_freq <= 16'd5000;
    pid_fb <= 16'd4000;
    run <= 1'b1;
    wait_chg(4'h1);
    out_freq <= 16'd3000;
    repeat (6100) @(posedge hclk);
    ahb(1'b0, `A_STATUS, 32'h0);
    chk_reg(rd, 32'h0100_0101);
    out_freq <= 16'd1000;
    pid_fb <= 16'd5000;
    wait_chg(4'h0);
    ahb(1'b0, `A_STATUS, 32'h0);
    chk_reg(rd, 32'h0000_0010);
    out_freq <= 16'd5000;
    pid_fb <= 16'd4000;
    wait_chg(4'h2);
    chk_relay({3'h0, ramp_restart}, 4'h0);
    out_freq <= 16'd3000;
    // all-motor rotation hands over to the next relay.
    ahb(1'b1, `A_CTRL, 32'h0000_0202);
    repeat (6100) @(posedge hclk);
    out_freq <= 16'd1000;
    wait_chg(4'h0);
    wait_chg(4'h4);
    ahb(1'b0, `A_STATUS, 32'h0);
    chk_reg(rd, 32'h0000_0024);
    end_of_test;
  end
endmodule
